/* File: src/perf_loop_defs.svh */
// Register offsets, field positions, reset values and timing figures of the
// performance-monitor and loopback register bank.
// Assumes it is included by bare name, once per compilation unit or guarded.
`ifndef PERF_LOOP_DEFS_SVH
`define PERF_LOOP_DEFS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define OFS_ERR_CFG 8'h41
`define OFS_LCV_HI 8'h42
`define OFS_LCV_LO 8'h43
`define OFS_PCV_HI 8'h44
`define OFS_PCV_LO 8'h45
`define OFS_FOS_HI 8'h46
`define OFS_FOS_LO 8'h47
`define OFS_FEB_HI 8'h48
`define OFS_FEB_LO 8'h49
`define OFS_LOOP_CTL 8'h4a
`define OFS_CHAN_1_8 8'h4b
`define OFS_CHAN_9_16 8'h4c
`define OFS_CHAN_17_24 8'h4d

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define CFG_MANUAL_UPDATE 6
`define CFG_PERIOD_SEL 5
`define CFG_ACCUM_MODE 4
`define CFG_E1_VIOL_TYPE 3
`define CFG_FS_REPORT 2
`define CFG_OOS_SELECT 1
`define CFG_EXZ_SELECT 0
`define CFG_WRITABLE_MASK 8'h7f
`define LOOP_MUX_CTL 4
`define LOOP_LOCAL 3
`define LOOP_REMOTE 2
`define LOOP_PAYLOAD 1
`define LOOP_FRAMER 0
`define LOOP_WRITABLE_MASK 8'h1f
`define REG_RESET 8'h00
`define COUNT_RESET 16'h0000
`define COUNT_MAX 16'hffff
`define READ_UNMAPPED 8'h00

// ----------------------------------------------------------------------------
// Timing figures
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 100
`define ONE_SECOND_NS 1000000000
`define T1_SHORT_FRAMES 333
`define E1_SHORT_FRAMES 500
`define FRAME_COUNT_WIDTH 9

`endif

/* File: src/perf_loop_pkg.sv */
// Types shared by the performance-monitor and loopback register bank.
// Assumes the defs header is included where the constants are needed.
package perf_loop_pkg;

   // -------------------------------------------------------------------------
   // Carriers
   // -------------------------------------------------------------------------
   // One bipolar line sample: a mark on the positive or the negative rail.
   typedef struct packed {
      logic pos;
      logic neg;
   } line_pair_t;

   // Single-cycle error events reported by the receive framer.
   typedef struct packed {
      logic bipolarViolation;
      logic codeViolation;
      logic excessZeros;
      logic ftError;
      logic fsError;
      logic framingBitError;
      logic multiframeOutOfSync;
      logic eBitError;
   } rx_events_t;

   // Source of the latch-and-restart trigger.
   typedef enum logic {
      UPDATE_TIMED,
      UPDATE_MANUAL
   } update_src_t;

endpackage

/* File: src/t1e1_perf_monitor_loopback.sv */
// Error-counter bank and loopback steering for a T1/E1 framer-transceiver.
// Assumes error events and frame strobes come from logic on clk, one cycle
// each, and that the mux-control pin is asynchronous to clk.
//
// Notes on behaviour
// - T1 latch: once a second, or every 333 frames.
// - E1 latch: once a second, or every 500 frames.
// - Accumulation mode picks timed or manual updates.
// - Manual bit rise latches counts two clocks later.
// - E1 line counter: bipolar or HDB3 code violations.
// - Path counter: Ft errors, plus Fs errors when enabled.
// - Out-of-sync counter: framing-bit errors or multiframes out of sync.
// - T1 line counter adds excessive zeros when selected.
// - Line violation count: 16 bits, 42h high, 43h low.
// - Path violation count: 16 bits, 44h high, 45h low.
// - Out-of-sync count: 16 bits, 46h high, 47h low.
// - Far-end error count: 16 bits, 48h high, 49h low.
// - Framer joins line interface only with pin high, mux bit clear.
// - Local loop feeds transmit data to receive.
// - Remote loop returns received line data to transmit.
// - Payload loop: transmit on recovered clock, transmit inputs ignored.
// - T1 payload loop returns 192 bits, overhead regenerated.
// - E1 payload loop returns 248 bits, overhead regenerated.
// - Framer loop: transmit to receive, T1 line sends unframed ones.
// - Channel loop bits source transmit channels from receive.
`timescale 1ns/100ps
`include "perf_loop_defs.svh"

module t1e1_perf_monitor_loopback
   import perf_loop_pkg::*;
#(
   parameter int SECOND_CYCLES = `ONE_SECOND_NS / `CLK_PERIOD_NS,
   parameter int CHANNELS = 24
) (
   input wire logic clk,
   input wire logic resetn,
   // Register port.
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [7:0] regReadData,
   // Receive framer status.
   input wire logic e1Mode,
   input wire logic frameStrobe,
   input wire rx_events_t rxEvents,
   // Mux-control pin, asynchronous.
   input wire logic muxControlPin,
   // Line and framer data paths.
   input wire line_pair_t rxLineIn,
   input wire line_pair_t txFormatterIn,
   input wire logic [4:0] txChannel,
   input wire logic txOverheadSlot,
   input wire logic txSerialBit,
   input wire logic txOverheadBit,
   input wire logic rxPayloadBit,
   output line_pair_t txLineOut,
   output line_pair_t rxFramerIn,
   output logic txPayloadBit,
   output logic framerToLineConnected,
   output logic txClockFromRecovered,
   output logic rxTimingFromTx,
   output logic localLoopViaJitter
);

   // --------
   // Registers and state
   // --------
   logic [7:0] cfg_q;
   logic [7:0] loopCtl_q;
   logic [CHANNELS-1:0] chanLoop_q;
   logic [15:0] lcvAcc_q;
   logic [15:0] pcvAcc_q;
   logic [15:0] fosAcc_q;
   logic [15:0] febAcc_q;
   logic [15:0] lcvCount_q;
   logic [15:0] pcvCount_q;
   logic [15:0] fosCount_q;
   logic [15:0] febCount_q;
   logic [31:0] secondTimer_q;
   logic [`FRAME_COUNT_WIDTH-1:0] frameTimer_q;
   logic manualPrev_q;
   logic manualPending_q;
   logic pinSync1_q;
   logic pinSync2_q;
   logic pinSync3_q;
   logic pinState_q;
   logic onesPhase_q;
   logic [7:0] regReadData_q;
   line_pair_t txLine_q;
   line_pair_t rxFramer_q;
   logic txPayload_q;
   logic connected_q;
   logic txFromRecovered_q;
   logic rxFromTx_q;
   logic localJitter_q;

   // Adds one event to a count, holding at full scale instead of wrapping.
   function automatic logic [15:0] satInc(input logic [15:0] value, input logic hit);
      logic [15:0] result;
      result = value;
      if (hit && value != `COUNT_MAX) begin
         result = value + 16'h0001;
      end
      return result;
   endfunction

   // Starts a fresh accumulation, counting an event that lands on the update.
   function automatic logic [15:0] restart(input logic hit);
      return hit ? 16'h0001 : `COUNT_RESET;
   endfunction

   // --------
   // Configuration decode
   // --------
   wire periodShort = cfg_q[`CFG_PERIOD_SEL];
   wire update_src_t updateSrc = update_src_t'(cfg_q[`CFG_ACCUM_MODE]);
   wire manualBit = cfg_q[`CFG_MANUAL_UPDATE];
   wire localLoop = loopCtl_q[`LOOP_LOCAL];
   wire remoteLoop = loopCtl_q[`LOOP_REMOTE];
   wire payloadLoop = loopCtl_q[`LOOP_PAYLOAD];
   wire framerLoop = loopCtl_q[`LOOP_FRAMER];
   wire muxBit = loopCtl_q[`LOOP_MUX_CTL];

   // Event selection into each counter.
   wire lcvE1Hit = cfg_q[`CFG_E1_VIOL_TYPE] ? rxEvents.codeViolation
      : rxEvents.bipolarViolation;
   wire lcvT1Hit = rxEvents.bipolarViolation
      | (cfg_q[`CFG_EXZ_SELECT] & rxEvents.excessZeros);
   wire lcvHit = e1Mode ? lcvE1Hit : lcvT1Hit;
   wire pcvHit = rxEvents.ftError | (cfg_q[`CFG_FS_REPORT] & rxEvents.fsError);
   wire fosHit = cfg_q[`CFG_OOS_SELECT] ? rxEvents.multiframeOutOfSync
      : rxEvents.framingBitError;
   wire febHit = rxEvents.eBitError;

   // --------
   // Update triggers
   // --------
   // The short period counts received frames rather than clocks, so it tracks
   // the line rate even when the recovered clock wanders.
   wire [`FRAME_COUNT_WIDTH-1:0] framesShort = e1Mode
      ? `FRAME_COUNT_WIDTH'(`E1_SHORT_FRAMES)
      : `FRAME_COUNT_WIDTH'(`T1_SHORT_FRAMES);
   wire frameTimerDone = frameStrobe
      && (frameTimer_q == framesShort - `FRAME_COUNT_WIDTH'(1));
   wire secondTimerDone = (secondTimer_q == 32'(SECOND_CYCLES - 1));
   wire timedUpdate = periodShort ? frameTimerDone : secondTimerDone;
   wire manualRise = manualBit & ~manualPrev_q;
   wire doUpdate = (updateSrc == UPDATE_TIMED) ? timedUpdate : manualPending_q;

   // Free-running one-second timer; it runs in both modes so a switch of mode
   // does not bring an early latch.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         secondTimer_q <= 32'h0000_0000;
      end else if (secondTimerDone) begin
         secondTimer_q <= 32'h0000_0000;
      end else begin
         secondTimer_q <= secondTimer_q + 32'h0000_0001;
      end
   end

   // Frame counter for the short update period.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         frameTimer_q <= '0;
      end else if (frameTimerDone) begin
         frameTimer_q <= '0;
      end else if (frameStrobe) begin
         frameTimer_q <= frameTimer_q + `FRAME_COUNT_WIDTH'(1);
      end
   end

   // Manual update: the rising edge is caught here and acted on the next clock.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         manualPrev_q <= 1'b0;
         manualPending_q <= 1'b0;
      end else begin
         manualPrev_q <= manualBit;
         manualPending_q <= manualRise && (updateSrc == UPDATE_MANUAL);
      end
   end

   // --------
   // Error counters
   // --------
   // Accumulators restart on update while the latched copies hold still, so a
   // high-then-low byte read sees one coherent count when no update falls between the two reads.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lcvAcc_q <= `COUNT_RESET;
         pcvAcc_q <= `COUNT_RESET;
         fosAcc_q <= `COUNT_RESET;
         febAcc_q <= `COUNT_RESET;
      end else if (doUpdate) begin
         lcvAcc_q <= restart(lcvHit);
         pcvAcc_q <= restart(pcvHit);
         fosAcc_q <= restart(fosHit);
         febAcc_q <= restart(febHit);
      end else begin
         lcvAcc_q <= satInc(lcvAcc_q, lcvHit);
         pcvAcc_q <= satInc(pcvAcc_q, pcvHit);
         fosAcc_q <= satInc(fosAcc_q, fosHit);
         febAcc_q <= satInc(febAcc_q, febHit);
      end
   end

   // Latched counts change only on an update.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         lcvCount_q <= `COUNT_RESET;
         pcvCount_q <= `COUNT_RESET;
         fosCount_q <= `COUNT_RESET;
         febCount_q <= `COUNT_RESET;
      end else if (doUpdate) begin
         lcvCount_q <= lcvAcc_q;
         pcvCount_q <= pcvAcc_q;
         fosCount_q <= fosAcc_q;
         febCount_q <= febAcc_q;
      end
   end

   // --------
   // Register port
   // --------
   wire wrCfg = regWrite && (regAddr == `OFS_ERR_CFG);
   wire wrLoop = regWrite && (regAddr == `OFS_LOOP_CTL);
   wire wrChan1 = regWrite && (regAddr == `OFS_CHAN_1_8);
   wire wrChan2 = regWrite && (regAddr == `OFS_CHAN_9_16);
   wire wrChan3 = regWrite && (regAddr == `OFS_CHAN_17_24);

   // Writable registers; the reserved top bits are dropped on write.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cfg_q <= `REG_RESET;
         loopCtl_q <= `REG_RESET;
         chanLoop_q <= '0;
      end else begin
         if (wrCfg) begin
            cfg_q <= regWriteData & `CFG_WRITABLE_MASK;
         end
         if (wrLoop) begin
            loopCtl_q <= regWriteData & `LOOP_WRITABLE_MASK;
         end
         if (wrChan1) begin
            chanLoop_q[7:0] <= regWriteData;
         end
         if (wrChan2) begin
            chanLoop_q[15:8] <= regWriteData;
         end
         if (wrChan3) begin
            chanLoop_q[23:16] <= regWriteData;
         end
      end
   end

   // Read multiplexer; unmapped addresses read as zero.
   logic [7:0] readMux;
   always_comb begin
      unique case (regAddr)
         `OFS_ERR_CFG: readMux = cfg_q;
         `OFS_LCV_HI: readMux = lcvCount_q[15:8];
         `OFS_LCV_LO: readMux = lcvCount_q[7:0];
         `OFS_PCV_HI: readMux = pcvCount_q[15:8];
         `OFS_PCV_LO: readMux = pcvCount_q[7:0];
         `OFS_FOS_HI: readMux = fosCount_q[15:8];
         `OFS_FOS_LO: readMux = fosCount_q[7:0];
         `OFS_FEB_HI: readMux = febCount_q[15:8];
         `OFS_FEB_LO: readMux = febCount_q[7:0];
         `OFS_LOOP_CTL: readMux = loopCtl_q;
         `OFS_CHAN_1_8: readMux = chanLoop_q[7:0];
         `OFS_CHAN_9_16: readMux = chanLoop_q[15:8];
         `OFS_CHAN_17_24: readMux = chanLoop_q[23:16];
         default: readMux = `READ_UNMAPPED;
      endcase
   end

   // Read data stand for exactly the cycle after the strobe.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         regReadData_q <= `REG_RESET;
      end else begin
         regReadData_q <= regRead ? readMux : `READ_UNMAPPED;
      end
   end

   // --------
   // Mux-control pin
   // --------
   // Three stages; the level is taken only once stages two and three agree,
   // which rejects a single-cycle glitch on the board pin.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinSync1_q <= 1'b0;
         pinSync2_q <= 1'b0;
         pinSync3_q <= 1'b0;
         pinState_q <= 1'b0;
      end else begin
         pinSync1_q <= muxControlPin;
         pinSync2_q <= pinSync1_q;
         pinSync3_q <= pinSync2_q;
         if (pinSync2_q == pinSync3_q) begin
            pinState_q <= pinSync3_q;
         end
      end
   end

   // --------
   // Loopback steering
   // --------
   wire connectedNext = pinState_q & ~muxBit;
   wire chanSelected = (txChannel < 5'(CHANNELS)) && chanLoop_q[txChannel];
   // Channel indices at or past CHANNELS never select a channel loop.

   // Unframed all ones alternates marks between the rails.
   wire line_pair_t allOnes = '{pos: onesPhase_q, neg: ~onesPhase_q};

   // Transmit line: framer loop in T1 overrides all, then remote loop.
   line_pair_t txLineNext;
   always_comb begin
      if (framerLoop && !e1Mode) begin
         txLineNext = allOnes;
      end else if (remoteLoop) begin
         txLineNext = rxLineIn;
      end else begin
         txLineNext = txFormatterIn;
      end
   end

   // Receive framer input: both framer and local loop take transmit data.
   wire line_pair_t rxFramerNext = (framerLoop || localLoop)
      ? txFormatterIn : rxLineIn;

   // Payload bit into the formatter: overhead slots keep the locally made
   // bits, payload slots take the receive side when looped.
   wire payloadFromRx = payloadLoop | chanSelected;
   wire txPayloadNext = txOverheadSlot ? txOverheadBit
      : (payloadFromRx ? rxPayloadBit : txSerialBit);

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         onesPhase_q <= 1'b0;
      end else begin
         onesPhase_q <= ~onesPhase_q;
      end
   end

   // Every path output is registered so the line sees no decode glitches.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         txLine_q <= '0;
         rxFramer_q <= '0;
         txPayload_q <= 1'b0;
         connected_q <= 1'b0;
         txFromRecovered_q <= 1'b0;
         rxFromTx_q <= 1'b0;
         localJitter_q <= 1'b0;
      end else begin
         txLine_q <= txLineNext;
         rxFramer_q <= rxFramerNext;
         txPayload_q <= txPayloadNext;
         connected_q <= connectedNext;
         txFromRecovered_q <= payloadLoop;
         rxFromTx_q <= framerLoop;
         localJitter_q <= localLoop;
      end
   end

   assign regReadData = regReadData_q;
   assign txLineOut = txLine_q;
   assign rxFramerIn = rxFramer_q;
   assign txPayloadBit = txPayload_q;
   assign framerToLineConnected = connected_q;
   assign txClockFromRecovered = txFromRecovered_q;
   assign rxTimingFromTx = rxFromTx_q;
   assign localLoopViaJitter = localJitter_q;

endmodule

/* File: tb/t1e1_perf_monitor_loopback_chk.sv */
// Checker for the counter and loopback bank, bound to its top module.
// Assumes the loop register changes only through the register port.
`timescale 1ns/100ps
module t1e1_perf_monitor_loopback_chk
   import perf_loop_pkg::*;
(
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] regAddr,
   input wire logic [7:0] regWriteData,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [7:0] regReadData,
   input wire logic e1Mode,
   input wire logic muxControlPin,
   input wire line_pair_t rxLineIn,
   input wire line_pair_t txFormatterIn,
   input wire logic txOverheadSlot,
   input wire logic txOverheadBit,
   input wire logic rxPayloadBit,
   input wire line_pair_t txLineOut,
   input wire line_pair_t rxFramerIn,
   input wire logic txPayloadBit,
   input wire logic framerToLineConnected
);
   logic [4:0] loopCtl_q;
   logic armed_q;
   logic t1Ones;
   logic rxLoop;

   // --------
   // Helpers
   // --------
   // Shadow of the loop register; armed_q skips the first edge after reset,
   // where registered paths still hold their reset value.
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         loopCtl_q <= 5'h00;
         armed_q <= 1'b0;
      end else begin
         armed_q <= 1'b1;
         if (regWrite && regAddr == 8'h4a) begin
            loopCtl_q <= regWriteData[4:0];
         end
      end
   end
   assign t1Ones = loopCtl_q[0] & ~e1Mode;
   assign rxLoop = loopCtl_q[3] | loopCtl_q[0];

   // --------
   // Properties
   // --------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn || !armed_q);

   AST_IDLE: assert property (!$past(regRead) |-> regReadData == 8'h00)
      else $error("read data outside a read");
   AST_REMOTE: assert property ($past(loopCtl_q[2]) && !$past(t1Ones)
      |-> txLineOut == $past(rxLineIn))
      else $error("remote loop path wrong");
   AST_TXNORM: assert property (!$past(loopCtl_q[2]) && !$past(t1Ones)
      |-> txLineOut == $past(txFormatterIn))
      else $error("transmit path wrong");
   AST_ONES: assert property ($past(t1Ones, 2) && $past(t1Ones)
      |-> txLineOut.pos != txLineOut.neg && txLineOut != $past(txLineOut))
      else $error("unframed ones wrong");
   AST_RXLOOP: assert property ($past(rxLoop) |-> rxFramerIn == $past(txFormatterIn))
      else $error("receive loop path wrong");
   AST_RXNORM: assert property (!$past(rxLoop) |-> rxFramerIn == $past(rxLineIn))
      else $error("receive path wrong");
   AST_OVHD: assert property ($past(txOverheadSlot)
      |-> txPayloadBit == $past(txOverheadBit))
      else $error("overhead not regenerated");
   AST_PAYLOOP: assert property ($past(loopCtl_q[1]) && !$past(txOverheadSlot)
      |-> txPayloadBit == $past(rxPayloadBit))
      else $error("payload loop wrong");
   AST_MUXON: assert property ((muxControlPin && !loopCtl_q[4])[*7]
      |-> framerToLineConnected)
      else $error("mux not joined");
   AST_MUXOFF: assert property ($past(loopCtl_q[4]) |-> !framerToLineConnected)
      else $error("mux joined while bit set");

   // Main scenarios reached.
   CV_ONES: cover property ($past(t1Ones) && t1Ones);
   CV_COUNT: cover property (regRead && regAddr == 8'h48);
   CV_MUX: cover property (framerToLineConnected);
endmodule

bind t1e1_perf_monitor_loopback t1e1_perf_monitor_loopback_chk chk_u (.clk, .resetn,
   .regAddr, .regWriteData, .regWrite, .regRead, .regReadData, .e1Mode, .muxControlPin,
   .rxLineIn, .txFormatterIn, .txOverheadSlot, .txOverheadBit, .rxPayloadBit,
   .txLineOut, .rxFramerIn, .txPayloadBit, .framerToLineConnected);

/* File: tb/line_side_model.sv */
// Stand-in for the line interface and the serial system side.
// Assumes a free-running clk; outputs change just after its rising edge.
`timescale 1ns/100ps
module line_side_model
   import perf_loop_pkg::*;
(
   input wire logic clk,
   output line_pair_t rxLineIn,
   output line_pair_t txFormatterIn,
   output logic [4:0] txChannel,
   output logic txOverheadSlot,
   output logic txSerialBit,
   output logic txOverheadBit,
   output logic rxPayloadBit
);
   int seed = 60517;
   logic [7:0] r;
   logic [4:0] slot;

   // Slots 0..23 carry channels and slot 24 overhead. Line marks never sit
   // on both rails at once, as a real bipolar line cannot.
   // Transmit timing stays on the bench clock, not the recovered one.
   initial begin
      {rxLineIn, txFormatterIn, txChannel} = 9'h000;
      {txOverheadSlot, txSerialBit, txOverheadBit, rxPayloadBit} = 4'h0;
   end
   always @(posedge clk) begin
      r = 8'($random(seed));
      slot = (txChannel == 5'd24) ? 5'd0 : txChannel + 5'd1;
      rxLineIn <= r[0] ? {r[1], ~r[1]} : 2'b00;
      txFormatterIn <= r[2] ? {r[3], ~r[3]} : 2'b00;
      txChannel <= slot;
      txOverheadSlot <= (slot == 5'd24);
      txSerialBit <= r[4];
      txOverheadBit <= r[5];
      rxPayloadBit <= r[6];
   end
endmodule

/* File: tb/t1e1_perf_monitor_loopback_tb_top.sv */
// Self-checking bench for the counter and loopback bank.
// Assumes the checker is bound in and the line model feeds the data paths.
`timescale 1ns/100ps
module t1e1_perf_monitor_loopback_tb_top
   import perf_loop_pkg::*;
;
   logic clk, resetn, regWrite, regRead, e1Mode, frameStrobe, muxControlPin;
   logic [7:0] regAddr, regWriteData, regReadData, got, cfg;
   rx_events_t rxEvents;
   line_pair_t rxLineIn, txFormatterIn, txLineOut, rxFramerIn;
   logic [4:0] txChannel, loopSh;
   logic txOverheadSlot, txSerialBit, txOverheadBit, rxPayloadBit, txPayloadBit;
   logic framerToLineConnected, txClockFromRecovered, rxTimingFromTx, localLoopViaJitter;
   logic [23:0] chanSh;
   logic [15:0] expCnt [4];
   logic [3:0] inc;
   logic [2:0] expFlags;
   logic expPay, watch;
   int fails = 0, checked = 0, cycles = 0, seed = 60517;

   // The one-second period is shortened so timed updates come every 50 clocks.
   t1e1_perf_monitor_loopback #(.SECOND_CYCLES(50)) dut_u (.clk, .resetn, .regAddr,
      .regWriteData, .regWrite, .regRead, .regReadData, .e1Mode, .frameStrobe, .rxEvents,
      .muxControlPin, .rxLineIn, .txFormatterIn, .txChannel, .txOverheadSlot, .txSerialBit,
      .txOverheadBit, .rxPayloadBit, .txLineOut, .rxFramerIn, .txPayloadBit,
      .framerToLineConnected, .txClockFromRecovered, .rxTimingFromTx, .localLoopViaJitter);
   line_side_model model_u (.clk, .rxLineIn, .txFormatterIn, .txChannel, .txOverheadSlot,
      .txSerialBit, .txOverheadBit, .rxPayloadBit);

   // --------
   // Tasks
   // --------
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic test_done;
      $display("compares %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Each bus cycle idles one clock after its strobe, so no strobe is set twice at once.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regWrite <= 1'b1;
      regAddr <= a;
      regWriteData <= d;
      @(posedge clk);
      regWrite <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a);
      regRead <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRead <= 1'b0;
      @(posedge clk);
      got = regReadData;
   endtask
   task automatic cnt(input int i, input logic [15:0] e);
      rd(8'h42 + 8'(2 * i));
      check("count hi", got, e[15:8]);
      rd(8'h43 + 8'(2 * i));
      check("count lo", got, e[7:0]);
   endtask
   task automatic poll(input logic [7:0] e);
      for (int i = 0; i < 60 && got !== e; i++) begin
         rd(8'h49);
      end
      check("timed update", got, e);
   endtask
   function automatic logic [3:0] incs(input rx_events_t v, input logic [7:0] c, input logic e1);
      incs[0] = e1 ? (c[3] ? v.codeViolation : v.bipolarViolation)
                   : (v.bipolarViolation | (c[0] & v.excessZeros));
      incs[1] = v.ftError | (c[2] & v.fsError);
      incs[2] = c[1] ? v.multiframeOutOfSync : v.framingBitError;
      incs[3] = v.eBitError;
   endfunction

   // --------
   // Clock, path model and time limit
   // --------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Registered outputs follow last cycle's inputs and register shadows.
   always @(posedge clk) begin
      cycles++;
      if (cycles > 20000) begin
         check("run time", 16'h0001, 16'h0000);
         test_done;
      end
      if (!resetn) begin
         watch = 1'b0;
         loopSh = 5'h00;
         chanSh = 24'h000000;
      end else begin
         if (watch) begin
            check("payload bit", txPayloadBit, expPay);
            check("loop flags", {txClockFromRecovered, rxTimingFromTx, localLoopViaJitter},
               expFlags);
         end
         expPay = txOverheadSlot ? txOverheadBit : (loopSh[1] ||
            (txChannel < 5'd24 && chanSh[txChannel])) ? rxPayloadBit : txSerialBit;
         expFlags = {loopSh[1], loopSh[0], loopSh[3]};
         watch = 1'b1;
         if (regWrite && regAddr == 8'h4a) loopSh = regWriteData[4:0];
         if (regWrite && regAddr == 8'h4b) chanSh[7:0] = regWriteData;
         if (regWrite && regAddr == 8'h4c) chanSh[15:8] = regWriteData;
         if (regWrite && regAddr == 8'h4d) chanSh[23:16] = regWriteData;
      end
   end

   // --------
   // Main sequence
   // --------
   initial begin
      resetn = 1'b0;
      {regWrite, regRead, e1Mode, frameStrobe, muxControlPin} = 5'h00;
      {regAddr, regWriteData, got} = 24'h000000;
      rxEvents = '0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      // Reset values, an unmapped place, read-only counts and reserved bits.
      for (int a = 8'h41; a <= 8'h4e; a++) begin
         rd(8'(a));
         check("reset value", got, 8'h00);
      end
      wr(8'h42, 8'h5a);
      rd(8'h42);
      check("read-only count", got, 8'h00);
      wr(8'h4a, 8'hff);
      rd(8'h4a);
      check("loop reg", got, 8'h1f);
      wr(8'h41, 8'hff);
      rd(8'h41);
      check("config reg", got, 8'h7f);
      wr(8'h41, 8'h00);
      wr(8'h4a, 8'h00);
      // Frame-timed updates: T1 latches at frame 333, E1 at frame 500.
      for (int m = 0; m < 2; m++) begin
         e1Mode <= m[0];
         wr(8'h41, 8'h20);
         rxEvents <= 8'h01;
         repeat (3 + m) @(posedge clk);
         rxEvents <= 8'h00;
         repeat ((m == 1) ? 499 : 332) begin
            frameStrobe <= 1'b1;
            @(posedge clk);
            frameStrobe <= 1'b0;
            @(posedge clk);
         end
         cnt(3, 16'(3 * m));
         frameStrobe <= 1'b1;
         @(posedge clk);
         frameStrobe <= 1'b0;
         @(posedge clk);
         cnt(3, 16'(3 + m));
      end
      // One-second timing: a single event shows in one period, then clears.
      wr(8'h41, 8'h00);
      rxEvents <= 8'h01;
      @(posedge clk);
      rxEvents <= 8'h00;
      poll(8'h01);
      poll(8'h00);
      // Manual updates across every source select and both line modes.
      for (int k = 0; k < 32; k++) begin
         cfg = {4'h1, 4'(k)};
         e1Mode <= k[4];
         wr(8'h41, cfg | 8'h40);
         wr(8'h41, cfg);
         for (int c = 0; c < 4; c++) expCnt[c] = 16'h0000;
         repeat (20) begin
            rxEvents <= rx_events_t'(8'($random(seed)));
            @(posedge clk);
            inc = incs(rxEvents, cfg, k[4]);
            for (int c = 0; c < 4; c++) expCnt[c] = expCnt[c] + 16'(inc[c]);
         end
         rxEvents <= 8'h00;
         wr(8'h41, cfg | 8'h40);
         @(posedge clk);
         for (int c = 0; c < 4; c++) cnt(c, expCnt[c]);
      end
      // Random loop settings, channel masks and mux pin levels.
      repeat (16) begin
         e1Mode <= 1'($random(seed));
         muxControlPin <= 1'($random(seed));
         wr(8'h4a, 8'($random(seed)));
         for (int j = 0; j < 3; j++) wr(8'h4b + 8'(j), 8'($random(seed)));
         repeat (10) @(posedge clk);
         check("mux joined", framerToLineConnected, muxControlPin & ~loopSh[4]);
         rd(8'h4a);
         check("loop reg", got, {3'b000, loopSh});
         rd(8'h4d);
         check("channel reg", got, chanSh[23:16]);
      end
      test_done;
   end
endmodule
